// ### hdl/chunk_stamp_params.svh
// constants, register map and field layout of the chunk stamp block
// Operation
// - 64-bit tick counter latched at trigger, appended
// - one tick represents 8 ns
// - tick counter restarts at camera reset
// - stamp taken at trigger, not readout
// - master enable gates every chunk kind
// - selector plus kind enable appends chunk
// - triggers numbered, count attached per image
// - 32-bit trigger count starts at one
// - after all ones wraps to zero
// - free-run mode makes trigger count unavailable
// - every trigger counts, even without frame
// - trigger count zero after power-up
// - host selects tally unit, trigger cause
// - clear origin line one, two, software, off
// - clear origin defaults to off
// - software clear command resets trigger count
// - counters wrap to zero after maximum
`ifndef CHUNK_STAMP_PARAMS_SVH
`define CHUNK_STAMP_PARAMS_SVH

// register byte offsets
`define REG_CHUNK_CTRL 12'h000
`define REG_CHUNK_ENA 12'h004
`define REG_CNT_CFG 12'h008
`define REG_CNT_CMD 12'h00C
`define REG_TS_LO 12'h010
`define REG_TS_HI 12'h014
`define REG_TRIG_CNT 12'h018
`define REG_STATUS 12'h01C
`define REG_CAP_TS_LO 12'h020
`define REG_CAP_TS_HI 12'h024
`define REG_CAP_TRIG 12'h028

// field positions
`define CTRL_MASTER_BIT 0
`define CTRL_FREERUN_BIT 1
`define KIND_LSB 0
`define KIND_W 2
`define CFG_ORIGIN_LSB 0
`define CFG_CAUSE_LSB 4
`define CFG_CHOICE_LSB 8
`define CMD_CLEAR_BIT 0
`define KIND_EN_BIT 31

// reset values
`define TICK_RESET 64'h0000_0000_0000_0000
`define TRIG_RESET 32'h0000_0000
`define TRIG_FIRST 32'h0000_0001

// timing
`define TICK_PERIOD_PS 8000
`define PCLK_PERIOD_PS 25000
// whole ticks per bus cycle and the residue carried between cycles
`define TICK_WHOLE (`PCLK_PERIOD_PS / `TICK_PERIOD_PS)
`define TICK_FRAC_PS (`PCLK_PERIOD_PS % `TICK_PERIOD_PS)
`define TICK_FRAC_RESET 16'h0000

`endif

// ### hdl/chunk_stamp_pkg.sv
// types shared by the chunk stamp block
package chunk_stamp_pkg;
    typedef enum logic [1:0] {
        ORIGIN_OFF = 2'h0,
        ORIGIN_LINE_ONE = 2'h1,
        ORIGIN_LINE_TWO = 2'h2,
        ORIGIN_SOFTWARE = 2'h3
    } clear_origin_e;
    typedef enum logic [1:0] {
        KIND_TIMESTAMP = 2'h0,
        KIND_TRIGGER_COUNT = 2'h1
    } chunk_kind_e;
    typedef enum logic [1:0] {
        CAUSE_ACQ_TRIGGER = 2'h0,
        CAUSE_NONE = 2'h1
    } increment_cause_e;
    typedef enum logic [1:0] {
        CHOICE_TRIGGER_TALLY = 2'h0,
        CHOICE_OTHER = 2'h1
    } counter_choice_e;
endpackage

// ### hdl/line_clear_if.sv
// link between the line edge detector and the stamp core
`timescale 1ns/10ps
interface line_clear_if;
    logic rise_one;
    logic rise_two;
    modport source (output rise_one, output rise_two);
    modport sink (input rise_one, input rise_two);
endinterface

// ### hdl/line_edge_sync.sv
// two-stage synchroniser and rising edge pulses for input lines
`timescale 1ns/10ps
module line_edge_sync (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic line_one, // input line one pin
    input wire logic line_two, // input line two pin
    line_clear_if.source edges // one-cycle rising edge pulses
);
    logic [1:0] meta;
    logic [1:0] stable;
    logic [1:0] prev;

    // synchronise then keep a delayed copy for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 2'h0;
            stable <= 2'h0;
            prev <= 2'h0;
        end else begin
            meta <= {line_two, line_one};
            stable <= meta;
            prev <= stable;
        end
    end

    // rising edges only
    assign edges.rise_one = stable[0] & ~prev[0];
    assign edges.rise_two = stable[1] & ~prev[1];
endmodule

// ### hdl/chunk_stamp.sv
// tick timestamp and trigger tally with chunk appending, apb slave
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "chunk_stamp_params.svh"
module chunk_stamp (
    input wire logic pclk, // bus clock, 40 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic acq_trigger, // external trigger pulse, same clock
    input wire logic frame_start, // frame acquired for this trigger
    input wire logic line_one, // input line one pin
    input wire logic line_two, // input line two pin
    output logic chunk_valid, // one-cycle chunk data pulse
    output logic chunk_ts_en, // timestamp chunk attached
    output logic chunk_trig_en, // trigger count chunk attached
    output logic [63:0] chunk_ts, // latched timestamp
    output logic [31:0] chunk_trig // trigger count for image
);
    line_clear_if lines ();

    line_edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .line_one(line_one),
        .line_two(line_two),
        .edges(lines.source)
    );

    ////////////////////////////////////////////////////////////////////
    // control registers
    logic master_en;
    logic free_run;
    logic [1:0] kind_sel;
    logic [1:0] kind_en;
    chunk_stamp_pkg::clear_origin_e origin;
    chunk_stamp_pkg::increment_cause_e cause;
    chunk_stamp_pkg::counter_choice_e choice;
    logic next_master_en;
    logic next_free_run;
    logic [1:0] next_kind_sel;
    logic [1:0] next_kind_en;
    chunk_stamp_pkg::clear_origin_e next_origin;
    chunk_stamp_pkg::increment_cause_e next_cause;
    chunk_stamp_pkg::counter_choice_e next_choice;
    logic wr;
    logic rd;
    logic sw_clear;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;

    // decode an address against the mapped set
    function automatic logic mapped(input logic [11:0] a);
        case (a)
            `REG_CHUNK_CTRL, `REG_CHUNK_ENA, `REG_CNT_CFG, `REG_CNT_CMD,
            `REG_TS_LO, `REG_TS_HI, `REG_TRIG_CNT, `REG_STATUS,
            `REG_CAP_TS_LO, `REG_CAP_TS_HI, `REG_CAP_TRIG: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    assign pslverr = psel & penable & ~mapped(paddr);

    // next control values from register writes
    always_comb begin
        next_master_en = master_en;
        next_free_run = free_run;
        next_kind_sel = kind_sel;
        next_kind_en = kind_en;
        next_origin = origin;
        next_cause = cause;
        next_choice = choice;
        if (wr && paddr == `REG_CHUNK_CTRL) begin
            next_master_en = pwdata[`CTRL_MASTER_BIT];
            next_free_run = pwdata[`CTRL_FREERUN_BIT];
            if (!pwdata[`CTRL_MASTER_BIT]) begin
                next_kind_en = 2'h0;
            end
        end
        if (wr && paddr == `REG_CHUNK_ENA) begin
            next_kind_sel = pwdata[`KIND_LSB +: `KIND_W];
            // enable only while master is on, kinds 0 and 1 exist
            if (master_en && pwdata[`KIND_LSB + 1] == 1'b0) begin
                next_kind_en[pwdata[`KIND_LSB]] = pwdata[`KIND_EN_BIT];
            end
        end
        if (wr && paddr == `REG_CNT_CFG) begin
            next_choice = chunk_stamp_pkg::counter_choice_e'(
                pwdata[`CFG_CHOICE_LSB +: 2]);
            // cause and origin are only written when the trigger tally is chosen
            if (pwdata[`CFG_CHOICE_LSB +: 2] == 2'(chunk_stamp_pkg::CHOICE_TRIGGER_TALLY)) begin
                next_cause = chunk_stamp_pkg::increment_cause_e'(
                    pwdata[`CFG_CAUSE_LSB +: 2]);
                next_origin = chunk_stamp_pkg::clear_origin_e'(
                    pwdata[`CFG_ORIGIN_LSB +: 2]);
            end
        end
    end

    // register the control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_en <= 1'b0;
            free_run <= 1'b0;
            kind_sel <= 2'h0;
            kind_en <= 2'h0;
            origin <= chunk_stamp_pkg::ORIGIN_OFF;
            cause <= chunk_stamp_pkg::CAUSE_ACQ_TRIGGER;
            choice <= chunk_stamp_pkg::CHOICE_TRIGGER_TALLY;
        end else begin
            master_en <= next_master_en;
            free_run <= next_free_run;
            kind_sel <= next_kind_sel;
            kind_en <= next_kind_en;
            origin <= next_origin;
            cause <= next_cause;
            choice <= next_choice;
        end
    end

    assign sw_clear = wr && paddr == `REG_CNT_CMD && pwdata[`CMD_CLEAR_BIT];

    ////////////////////////////////////////////////////////////////////
    // counters
    logic [63:0] tick;
    logic [15:0] tick_frac;
    logic [15:0] next_tick_frac;
    logic [15:0] frac_sum;
    logic [31:0] trig_cnt;
    logic first_cycle;
    logic [63:0] next_tick;
    logic [31:0] next_trig_cnt;
    logic next_first_cycle;
    logic clear_req;
    logic count_trig;
    logic tally_on;

    // clear request from the selected origin
    always_comb begin
        unique case (origin)
            chunk_stamp_pkg::ORIGIN_OFF: clear_req = 1'b0;
            chunk_stamp_pkg::ORIGIN_LINE_ONE: clear_req = lines.rise_one;
            chunk_stamp_pkg::ORIGIN_LINE_TWO: clear_req = lines.rise_two;
            chunk_stamp_pkg::ORIGIN_SOFTWARE: clear_req = sw_clear;
        endcase
    end

    assign tally_on = ~free_run & (cause == chunk_stamp_pkg::CAUSE_ACQ_TRIGGER);
    assign count_trig = acq_trigger & tally_on;

    // tick advances 3 or 4 units per bus cycle, residue carried keeps 8 ns per unit
    always_comb begin
        frac_sum = tick_frac + 16'(`TICK_FRAC_PS);
        if (frac_sum >= 16'(`TICK_PERIOD_PS)) begin
            next_tick_frac = frac_sum - 16'(`TICK_PERIOD_PS);
            next_tick = tick + 64'(`TICK_WHOLE) + 64'h0000_0000_0000_0001;
        end else begin
            next_tick_frac = frac_sum;
            next_tick = tick + 64'(`TICK_WHOLE);
        end
        next_trig_cnt = trig_cnt;
        next_first_cycle = first_cycle;
        if (clear_req) begin
            next_trig_cnt = `TRIG_RESET;
            next_first_cycle = 1'b0;
        end else if (count_trig) begin
            if (first_cycle && trig_cnt == `TRIG_RESET) begin
                next_trig_cnt = `TRIG_FIRST;
            end else begin
                next_trig_cnt = trig_cnt + 32'h0000_0001;
            end
        end
        // a clear in the same cycle as a trigger still counts that trigger, count becomes one
        if (clear_req && count_trig) begin
            next_trig_cnt = `TRIG_FIRST;
        end
    end

    // counter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= `TICK_RESET;
            tick_frac <= `TICK_FRAC_RESET;
            trig_cnt <= `TRIG_RESET;
            first_cycle <= 1'b1;
        end else begin
            tick <= next_tick;
            tick_frac <= next_tick_frac;
            trig_cnt <= next_trig_cnt;
            first_cycle <= next_first_cycle;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // chunk capture
    logic [63:0] next_chunk_ts;
    logic [31:0] next_chunk_trig;
    logic next_chunk_valid;
    logic next_ts_en;
    logic next_trig_en;

    // stamp and count taken at the trigger, presented at frame start
    always_comb begin
        next_chunk_ts = chunk_ts;
        next_chunk_trig = chunk_trig;
        next_chunk_valid = 1'b0;
        next_ts_en = chunk_ts_en;
        next_trig_en = chunk_trig_en;
        if (acq_trigger) begin
            next_chunk_ts = tick;
            next_chunk_trig = tally_on ? next_trig_cnt : `TRIG_RESET;
        end
        if (frame_start) begin
            next_chunk_valid = master_en;
            next_ts_en = master_en & kind_en[0];
            next_trig_en = master_en & kind_en[1] & tally_on;
        end
    end

    // chunk output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chunk_ts <= `TICK_RESET;
            chunk_trig <= `TRIG_RESET;
            chunk_valid <= 1'b0;
            chunk_ts_en <= 1'b0;
            chunk_trig_en <= 1'b0;
        end else begin
            chunk_ts <= next_chunk_ts;
            chunk_trig <= next_chunk_trig;
            chunk_valid <= next_chunk_valid;
            chunk_ts_en <= next_ts_en;
            chunk_trig_en <= next_trig_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                `REG_CHUNK_CTRL: prdata = {30'h0, free_run, master_en};
                `REG_CHUNK_ENA: prdata = {kind_en[kind_sel[0]], 29'h0, kind_sel};
                `REG_CNT_CFG: prdata = {22'h0, choice, 2'h0, cause, 2'h0, origin};
                `REG_TS_LO: prdata = tick[31:0];
                `REG_TS_HI: prdata = tick[63:32];
                `REG_TRIG_CNT: prdata = trig_cnt;
                `REG_STATUS: prdata = {29'h0, tally_on, kind_en};
                `REG_CAP_TS_LO: prdata = chunk_ts[31:0];
                `REG_CAP_TS_HI: prdata = chunk_ts[63:32];
                `REG_CAP_TRIG: prdata = chunk_trig;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

// ### test/chunk_stamp_properties.sv
// port assertions for the chunk stamp block
`timescale 1ns/10ps
module chunk_stamp_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // apb error
    input wire logic acq_trigger, // trigger pulse
    input wire logic frame_start, // frame pulse
    input wire logic chunk_valid, // chunk pulse
    input wire logic chunk_ts_en, // stamp attached
    input wire logic chunk_trig_en, // count attached
    input wire logic [63:0] chunk_ts, // stamp
    input wire logic [31:0] chunk_trig // count
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ts_hold;
        !acq_trigger |=> $stable(chunk_ts);
    endproperty
    a_ts_hold: assert property (p_ts_hold) else $error("stamp moved");
    property p_ts_step;
        acq_trigger ##1 acq_trigger |=> (chunk_ts - $past(chunk_ts)) inside {64'h3, 64'h4};
    endproperty
    a_ts_step: assert property (p_ts_step) else $error("tick step");
    property p_trig_step;
        acq_trigger ##1 (acq_trigger && chunk_trig != 32'h0) |=>
            chunk_trig == $past(chunk_trig) + 32'h1;
    endproperty
    a_trig_step: assert property (p_trig_step) else $error("count step");
    property p_valid;
        chunk_valid |-> $past(frame_start);
    endproperty
    a_valid: assert property (p_valid) else $error("stray chunk");
    property p_en_hold;
        !frame_start |=> $stable({chunk_ts_en, chunk_trig_en});
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved");
    property p_rst;
        $rose(presetn) |-> chunk_ts == 64'h0 && chunk_trig == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_idle;
        !(psel && penable) |-> prdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data idle");
    cover property (acq_trigger ##1 acq_trigger);
    cover property (chunk_valid && chunk_trig_en);
    cover property (pslverr);
endmodule
bind chunk_stamp chunk_stamp_checker i_chunk_stamp_checker (.pclk, .presetn, .psel,
    .penable, .prdata, .pslverr, .acq_trigger, .frame_start, .chunk_valid,
    .chunk_ts_en, .chunk_trig_en, .chunk_ts, .chunk_trig);

// ### test/host_model.sv
// host side: receives images and parses their chunks
`timescale 1ns/10ps
module host_model (
    input wire logic pclk, // clock
    input wire logic chunk_valid, // chunk pulse
    input wire logic chunk_trig_en, // count attached
    input wire logic [31:0] chunk_trig, // count
    output int images, // images received
    output logic [31:0] last_trig // last parsed count
);
    // no images seen before the run starts
    initial images = 0;

    // parse the count chunk only when attached
    always @(posedge pclk) begin
        if (chunk_valid === 1'b1) begin
            images <= images + 1;
            if (chunk_trig_en === 1'b1) begin
                last_trig <= chunk_trig;
            end
        end
    end
endmodule

// ### test/tb.sv
// self-checking bench for the chunk stamp block
`timescale 1ns/10ps
`include "chunk_stamp_params.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, acq_trigger, frame_start, line_one, line_two;
    logic pready, pslverr, chunk_valid, chunk_ts_en, chunk_trig_en, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, chunk_trig, last_trig, exp_trig;
    logic [63:0] chunk_ts, exp_ts;
    int bad_count = 0, checks_done = 0, cycles = 0, images, nimg = 0, free = 0, ups = 0;
    int seed = 32'hbac0, g, h;
    chunk_stamp i_chunk_stamp (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .acq_trigger, .frame_start, .line_one, .line_two,
        .chunk_valid, .chunk_ts_en, .chunk_trig_en, .chunk_ts, .chunk_trig);
    host_model i_host_model (.pclk, .chunk_valid, .chunk_trig_en, .chunk_trig, .images,
        .last_trig);
    ////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task trig(input int hi, input int gap);
        @(posedge pclk);
        acq_trigger <= 1'b1;
        repeat (hi) @(posedge pclk);
        acq_trigger <= 1'b0;
        exp_trig = free ? 32'h0 : exp_trig + hi;
        #1;
        chk(chunk_trig, exp_trig);
        exp_ts = longint'(ups - 1) * `PCLK_PERIOD_PS / `TICK_PERIOD_PS;
        chk(chunk_ts, exp_ts);
        repeat (gap) @(posedge pclk);
    endtask
    task frame;
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        nimg++;
    endtask
    task line(input int which);
        @(posedge pclk);
        line_one <= (which == 1);
        line_two <= (which == 2);
        repeat (3) @(posedge pclk);
        line_one <= 1'b0;
        line_two <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, acq_trigger} = '0;
        {frame_start, line_one, line_two, presetn, exp_trig} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `REG_CNT_CFG, 0);
        chk(rd[1:0], chunk_stamp_pkg::ORIGIN_OFF);
        apb(0, `REG_TRIG_CNT, 0);
        chk(rd, 0);
        apb(1, `REG_CHUNK_ENA, 32'h8000_0000);
        apb(0, `REG_STATUS, 0);
        chk(rd[1:0], 0);
        apb(1, `REG_CHUNK_CTRL, 1);
        for (int k = 0; k < 2; k++) apb(1, `REG_CHUNK_ENA, 32'h8000_0000 | k);
        apb(1, `REG_CNT_CFG, 0);
        frame();
        chk({chunk_ts_en, chunk_trig_en}, 2'b11);
        $display("setup done");
        for (int i = 0; i < 10; i++) begin
            h = 1 + ($random(seed) & 1);
            g = $random(seed) & 7;
            trig(h, g);
            if (g[0]) frame();
            if (g[0]) chk(last_trig, exp_trig);
        end
        chk(images, nimg);
        $display("count done");
        for (int o = 0; o < 4; o++) begin
            for (int s = 1; s < 4; s++) begin
                apb(1, `REG_CNT_CFG, o);
                trig(1, 0);
                if (s == 3) apb(1, `REG_CNT_CMD, 1);
                else line(s);
                if (s == o) exp_trig = 0;
                apb(0, `REG_TRIG_CNT, 0);
                chk(rd, exp_trig);
            end
        end
        $display("clear done");
        free = 1;
        apb(1, `REG_CHUNK_CTRL, 3);
        trig(1, 2);
        apb(1, `REG_CHUNK_CTRL, 0);
        frame();
        chk({chunk_ts_en, chunk_trig_en}, 2'b00);
        apb(1, 12'h0FC, $random(seed));
        chk(err, 1);
        apb(0, 12'h0FC, 0);
        chk({err, rd}, 33'h1_0000_0000);
        $display("refusal done");
        stop_test;
    end
    // bus cycles out of reset, the time base of the tick model
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            ups <= ups + 1;
        end
    end
    // watchdog
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test;
        end
    end
endmodule
